/* File: uif_core.sv */
// Interrupt identification and FIFO control of one UART channel.
// Notes on behaviour
// - Outside 256-byte mode, status bits 7 and 6 both mirror FIFO enable.
// - In 256-byte mode, status bit 7 is 0 when TX FIFO holds 256.
// - In 256-byte mode, status bit 6 is 1 when RX FIFO holds 256.
// - TX count zero: bit 7 high means empty, low means 256 stored.
// - RX count zero: bit 6 high means 256 stored, low means empty.
// - Bits 5:0 carry the winning source code, 00_0001 when none pends.
// - Line errors rank first with code 00_0110; line status read clears.
// - RX level at trigger gives 00_0100; cleared when level drops below.
// - Four idle character times with data give 00_1100; RX read clears.
// - TX empty or trigger crossing gives 00_0010; status read, write clear.
// - Modem line change gives 00_0000; modem status read clears it.
// - Xoff or special character gives 01_0000; status read clears it.
// - RTS or CTS rising in auto flow gives 10_0000, lowest; read clears.
// - Control bits 7:6 pick RX trigger 8, 16, 56 or 60; reset 00.
// - Control bits 5:4 pick TX trigger 8, 16, 32 or 56; reset 00.
// - TX trigger bits change only while enhanced features are enabled.
// - Control bit 3 selects DMA mode 0 or 1, mode 0 by default.
// - Writing control bit 2 resets TX pointers and count; bit self-clears.
// - Writing control bit 1 resets RX pointers and count; bit self-clears.
// - Control bit 0 enables both FIFOs; disabled after reset.
// - FIFOs hold 64 bytes, 256 in big mode, one location when disabled.
// - A source reports only while its interrupt enable bit is set.
`timescale 1ns/1ps
module uif_core
    import uif_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Register accesses
    input wire logic fcWrite,
    input wire logic [7:0] fcData,
    input wire logic idRead,
    input wire logic lineStatusRead,
    input wire logic rxBufRead,
    input wire logic modemStatusRead,
    input wire logic txHoldWrite,
    input wire logic [7:0] intEnable,
    input wire uif_enh_s enh,
    // Events and pins
    input wire uif_evt_s evt,
    input wire logic charTick,
    input wire logic rtsPin,
    input wire logic ctsPin,
    input wire logic txPop,
    // Received characters
    input wire logic rxInValid,
    input wire logic [DATA_W-1:0] rxInData,
    output logic rxInReady,
    // RX FIFO storage write
    output logic rxMemWe,
    output logic [PTR_W-1:0] rxMemAddr,
    output logic [DATA_W-1:0] rxMemData,
    // FIFO state
    output logic [PTR_W-1:0] txWrPtr,
    output logic [PTR_W-1:0] txRdPtr,
    output logic [PTR_W-1:0] rxRdPtr,
    output logic [7:0] txLevel,
    output logic [7:0] rxLevel,
    output logic fifoEnable,
    output logic dmaMode,
    // Interrupt identification read data
    output logic [7:0] idData
);

    typedef struct packed {
        logic fcEn;
        logic dma;
        logic [1:0] rxTrig;
        logic [1:0] txTrig;
        logic [PTR_W-1:0] txWr;
        logic [PTR_W-1:0] txRd;
        logic [CNT_W-1:0] txCount;
        logic [PTR_W-1:0] rxWr;
        logic [PTR_W-1:0] rxRd;
        logic [CNT_W-1:0] rxCount;
        logic lsrPend;
        logic thrPend;
        logic msPend;
        logic xoffPend;
        logic rtsPend;
        logic ctsPend;
        logic toutPend;
        logic [2:0] toutCnt;
        logic txAbove;
        logic txWasEmpty;
        logic [2:0] rtsSync;
        logic [2:0] ctsSync;
        logic rtsLvl;
        logic ctsLvl;
        logic [7:0] idData;
    } uif_state_s;

    // TX counts as already empty after reset, so no false TX empty edge.
    localparam uif_state_s STATE_RESET = '{txWasEmpty: 1'b1, default: '0};

    uif_state_s s_q;
    uif_state_s s_d;

    logic bufValid;
    logic [DATA_W-1:0] bufData;
    logic [CNT_W-1:0] depth;
    logic [CNT_W-1:0] depthM1;
    logic [PTR_W-1:0] mask;
    logic txFull;
    logic rxFull;
    logic txPush;
    logic txPopDo;
    logic rxPush;
    logic rxPopDo;
    logic [CNT_W-1:0] rxTrigLvl;
    logic [CNT_W-1:0] txTrigLvl;
    logic rdaActive;
    logic txAboveNow;
    logic threSet;
    logic rtsRise;
    logic ctsRise;
    logic toutIdle;
    logic [5:0] code;
    logic [7:0] idValue;

    // ************************************************************
    // Received character buffer
    // ************************************************************
    uif_pair_buffer u_rx_buf (
        .clk(clk),
        .reset_n(reset_n),
        .inValid(rxInValid),
        .inReady(rxInReady),
        .inData(rxInData),
        .outValid(bufValid),
        .outReady(rxPush),
        .outData(bufData)
    );

    // ************************************************************
    // FIFO geometry and handshakes
    // ************************************************************
    always_comb begin
        depth = DEPTH_OFF;
        if (s_q.fcEn) begin
            depth = enh.fifo256 ? DEPTH_256 : DEPTH_64;
        end
    end

    assign depthM1 = depth - 9'h001;
    assign mask = depthM1[PTR_W-1:0];
    // A FIFO disabled while it held data must not take more entries.
    assign txFull = (s_q.txCount >= depth);
    assign rxFull = (s_q.rxCount >= depth);
    assign txPush = txHoldWrite && !txFull;
    assign txPopDo = txPop && (s_q.txCount != 9'h000);
    assign rxPush = bufValid && !rxFull;
    assign rxPopDo = rxBufRead && (s_q.rxCount != 9'h000);

    assign rxTrigLvl = s_q.fcEn ? RX_TRIG[s_q.rxTrig] : DEPTH_OFF;
    assign txTrigLvl = TX_TRIG[s_q.txTrig];
    assign rdaActive = (s_q.rxCount >= rxTrigLvl);
    assign txAboveNow = (s_q.txCount > txTrigLvl);
    assign threSet = ((s_q.txCount == 9'h000) && !s_q.txWasEmpty)
        || (s_q.fcEn && s_q.txAbove && !txAboveNow);

    // Pin levels count once the second and third stages agree.
    assign rtsRise = enh.autoRts && (s_q.rtsSync[1] == s_q.rtsSync[2])
        && s_q.rtsSync[1] && !s_q.rtsLvl;
    assign ctsRise = enh.autoCts && (s_q.ctsSync[1] == s_q.ctsSync[2])
        && s_q.ctsSync[1] && !s_q.ctsLvl;

    assign toutIdle = !s_q.fcEn || (s_q.rxCount == 9'h000) || rxPush
        || rxBufRead;

    // ************************************************************
    // Priority encoder
    // ************************************************************
    always_comb begin
        code = CODE_NONE;
        if (s_q.lsrPend && intEnable[IE_LINE]) begin
            code = CODE_LINE;
        end else if (rdaActive && intEnable[IE_RXDATA]) begin
            code = CODE_RXDATA;
        end else if (s_q.toutPend && intEnable[IE_RXDATA]) begin
            code = CODE_TIMEOUT;
        end else if (s_q.thrPend && intEnable[IE_THRE]) begin
            code = CODE_THRE;
        end else if (s_q.msPend && intEnable[IE_MODEM]) begin
            code = CODE_MODEM;
        end else if (s_q.xoffPend && intEnable[IE_XOFF]) begin
            code = CODE_XOFF;
        end else if ((s_q.rtsPend && intEnable[IE_RTS])
            || (s_q.ctsPend && intEnable[IE_CTS])) begin
            code = CODE_FLOW;
        end
    end

    always_comb begin
        idValue = {s_q.fcEn, s_q.fcEn, code};
        if (enh.fifo256) begin
            idValue[7] = (s_q.txCount != DEPTH_256);
            idValue[6] = (s_q.rxCount == DEPTH_256);
        end
    end

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb begin
        s_d = s_q;
        // TX pointers and level.
        if (txPush) begin
            s_d.txWr = (s_q.txWr + 8'h01) & mask;
        end
        if (txPopDo) begin
            s_d.txRd = (s_q.txRd + 8'h01) & mask;
        end
        if (txPush && !txPopDo) begin
            s_d.txCount = s_q.txCount + 9'h001;
        end else if (txPopDo && !txPush) begin
            s_d.txCount = s_q.txCount - 9'h001;
        end
        // RX pointers and level.
        if (rxPush) begin
            s_d.rxWr = (s_q.rxWr + 8'h01) & mask;
        end
        if (rxPopDo) begin
            s_d.rxRd = (s_q.rxRd + 8'h01) & mask;
        end
        if (rxPush && !rxPopDo) begin
            s_d.rxCount = s_q.rxCount + 9'h001;
        end else if (rxPopDo && !rxPush) begin
            s_d.rxCount = s_q.rxCount - 9'h001;
        end
        // FIFO control writes; the reset bits are never stored.
        if (fcWrite) begin
            s_d.fcEn = fcData[FC_ENABLE];
            s_d.dma = fcData[FC_DMA];
            s_d.rxTrig = fcData[FC_RXTRIG +: 2];
            if (enh.enhEnable) begin
                s_d.txTrig = fcData[FC_TXTRIG +: 2];
            end
            if (fcData[FC_TXRST]) begin
                s_d.txWr = 8'h00;
                s_d.txRd = 8'h00;
                s_d.txCount = 9'h000;
            end
            if (fcData[FC_RXRST]) begin
                s_d.rxWr = 8'h00;
                s_d.rxRd = 8'h00;
                s_d.rxCount = 9'h000;
            end
        end
        // Pending sources; a set in the clearing cycle wins.
        s_d.lsrPend = evt.lineErr
            || (s_q.lsrPend && !lineStatusRead);
        s_d.msPend = evt.modemChange
            || (s_q.msPend && !modemStatusRead);
        s_d.thrPend = threSet || (s_q.thrPend && !txPush
            && !(idRead && code == CODE_THRE));
        s_d.xoffPend = evt.xoffDetect || (s_q.xoffPend
            && !(idRead && code == CODE_XOFF));
        s_d.rtsPend = rtsRise || (s_q.rtsPend
            && !(idRead && code == CODE_FLOW));
        s_d.ctsPend = ctsRise || (s_q.ctsPend
            && !(idRead && code == CODE_FLOW));
        s_d.txAbove = txAboveNow;
        s_d.txWasEmpty = (s_q.txCount == 9'h000);
        // Character timeout counts idle character times.
        if (toutIdle) begin
            s_d.toutCnt = 3'h0;
        end else if (charTick && s_q.toutCnt != TOUT_CHARS) begin
            s_d.toutCnt = s_q.toutCnt + 3'h1;
        end
        if (!toutIdle && charTick && s_q.toutCnt == TOUT_CHARS - 3'h1) begin
            s_d.toutPend = 1'b1;
        end else if (rxBufRead) begin
            s_d.toutPend = 1'b0;
        end
        // Pin synchronisers.
        s_d.rtsSync = {s_q.rtsSync[1:0], rtsPin};
        s_d.ctsSync = {s_q.ctsSync[1:0], ctsPin};
        if (s_q.rtsSync[1] == s_q.rtsSync[2]) begin
            s_d.rtsLvl = s_q.rtsSync[1];
        end
        if (s_q.ctsSync[1] == s_q.ctsSync[2]) begin
            s_d.ctsLvl = s_q.ctsSync[1];
        end
        if (idRead) begin
            s_d.idData = idValue;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            s_q <= STATE_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    assign rxMemWe = rxPush;
    assign rxMemAddr = s_q.rxWr;
    assign rxMemData = bufData;
    assign txWrPtr = s_q.txWr;
    assign txRdPtr = s_q.txRd;
    assign rxRdPtr = s_q.rxRd;
    assign txLevel = s_q.txCount[7:0];
    assign rxLevel = s_q.rxCount[7:0];
    assign fifoEnable = s_q.fcEn;
    assign dmaMode = s_q.dma;
    assign idData = s_q.idData;

    // ************************************************************
    // Checks
    // ************************************************************
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);

    a_mirror_enable:
        assert property (idRead && !enh.fifo256
            |=> idData[7:6] == {2{$past(s_q.fcEn)}})
        else $error("status bits 7:6 do not mirror FIFO enable");
    a_tx_full_flag:
        assert property (idRead && enh.fifo256 && s_q.txCount == DEPTH_256
            |=> !idData[7] && txLevel == $past(s_q.txCount[7:0]))
        else $error("full TX FIFO not shown in status bit 7");
    a_rx_full_flag:
        assert property (idRead && enh.fifo256 && s_q.rxCount == DEPTH_256
            |=> idData[6])
        else $error("full RX FIFO not shown in status bit 6");
    a_none_code:
        assert property (idRead && intEnable == 8'h00
            |=> idData[5:0] == CODE_NONE)
        else $error("source reported with all enables clear");
    a_line_first:
        assert property (idRead && s_q.lsrPend && intEnable[IE_LINE]
            |=> idData[5:0] == CODE_LINE)
        else $error("line status did not win priority");
    a_line_clear:
        assert property (lineStatusRead && !evt.lineErr |=> !s_q.lsrPend)
        else $error("line status source not cleared by read");
    a_thre_keep:
        assert property (idRead && s_q.thrPend && code != CODE_THRE
            && !txPush |=> s_q.thrPend)
        else $error("TX empty lost on unrelated status read");
    a_trig_lock:
        assert property (fcWrite && !enh.enhEnable
            |=> $stable(s_q.txTrig))
        else $error("TX trigger changed without enhanced features");
    a_tx_reset:
        assert property (fcWrite && fcData[FC_TXRST]
            |=> txLevel == 8'h00 && txWrPtr == 8'h00)
        else $error("TX FIFO reset did not complete in one clock");
    a_rx_reset:
        assert property (fcWrite && fcData[FC_RXRST] && !rxPush
            |=> rxLevel == 8'h00 ##1 !rxPush || rxMemAddr == 8'h00)
        else $error("RX FIFO reset did not complete in one clock");
    a_timeout_clear:
        assert property (rxBufRead |=> !s_q.toutPend)
        else $error("character timeout not cleared by RX read");
    a_disabled_depth:
        assert property (!s_q.fcEn && s_q.rxCount != 9'h000 |-> !rxPush)
        else $error("disabled FIFO takes more than one entry");

endmodule // uif_core

/* File: uif_pkg.sv */
// Constants, field layouts and carrier types of the interrupt and FIFO control.
package uif_pkg;

    // ************************************************************
    // Widths and FIFO depths
    // ************************************************************
    localparam int unsigned DATA_W = 8;
    localparam int unsigned PTR_W = 8;
    localparam int unsigned CNT_W = 9;
    localparam logic [8:0] DEPTH_256 = 9'h100;
    localparam logic [8:0] DEPTH_64 = 9'h040;
    localparam logic [8:0] DEPTH_OFF = 9'h001;
    localparam logic [1:0] BUF_ENTRIES = 2'h2;

    // ************************************************************
    // Interrupt identification codes
    // ************************************************************
    localparam logic [5:0] CODE_NONE = 6'h01;
    localparam logic [5:0] CODE_LINE = 6'h06;
    localparam logic [5:0] CODE_RXDATA = 6'h04;
    localparam logic [5:0] CODE_TIMEOUT = 6'h0c;
    localparam logic [5:0] CODE_THRE = 6'h02;
    localparam logic [5:0] CODE_MODEM = 6'h00;
    localparam logic [5:0] CODE_XOFF = 6'h10;
    localparam logic [5:0] CODE_FLOW = 6'h20;

    // ************************************************************
    // Field positions of fifo_control and interrupt_enable
    // ************************************************************
    localparam int unsigned FC_ENABLE = 0;
    localparam int unsigned FC_RXRST = 1;
    localparam int unsigned FC_TXRST = 2;
    localparam int unsigned FC_DMA = 3;
    localparam int unsigned FC_TXTRIG = 4;
    localparam int unsigned FC_RXTRIG = 6;
    localparam int unsigned IE_RXDATA = 0;
    localparam int unsigned IE_THRE = 1;
    localparam int unsigned IE_LINE = 2;
    localparam int unsigned IE_MODEM = 3;
    localparam int unsigned IE_XOFF = 5;
    localparam int unsigned IE_RTS = 6;
    localparam int unsigned IE_CTS = 7;

    // ************************************************************
    // Values after reset and trigger tables
    // ************************************************************
    localparam logic FC_ENABLE_RESET = 1'b0;
    localparam logic FC_DMA_RESET = 1'b0;
    localparam logic [1:0] TRIG_RESET = 2'h0;
    localparam logic [8:0] RX_TRIG [4] = '{9'h008, 9'h010, 9'h038, 9'h03c};
    localparam logic [8:0] TX_TRIG [4] = '{9'h008, 9'h010, 9'h020, 9'h038};

    // ************************************************************
    // Character time counts
    // ************************************************************
    localparam logic [2:0] TOUT_CHARS = 3'h4;

    // ************************************************************
    // Carrier types
    // ************************************************************
    typedef struct packed {
        logic autoCts;
        logic autoRts;
        logic enhEnable;
        logic fifo256;
    } uif_enh_s;

    typedef struct packed {
        logic lineErr;
        logic modemChange;
        logic xoffDetect;
    } uif_evt_s;

endpackage

/* File: uif_pair_buffer.sv */
// Two-entry buffer with valid and ready on both sides.
`timescale 1ns/1ps
module uif_pair_buffer
    import uif_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Filling side
    input wire logic inValid,
    output logic inReady,
    input wire logic [DATA_W-1:0] inData,
    // Draining side
    output logic outValid,
    input wire logic outReady,
    output logic [DATA_W-1:0] outData
);

    typedef struct packed {
        logic [1:0] cnt;
        logic [DATA_W-1:0] slot0;
        logic [DATA_W-1:0] slot1;
    } uif_buf_s;

    uif_buf_s s_q;
    uif_buf_s s_d;
    logic push;
    logic pop;

    assign inReady = (s_q.cnt != BUF_ENTRIES);
    assign outValid = (s_q.cnt != 2'h0);
    assign outData = s_q.slot0;
    assign push = inValid && inReady;
    assign pop = outValid && outReady;

    always_comb begin
        s_d = s_q;
        if (push && pop) begin
            if (s_q.cnt == 2'h1) begin
                s_d.slot0 = inData;
            end else begin
                s_d.slot0 = s_q.slot1;
                s_d.slot1 = inData;
            end
        end else if (push) begin
            if (s_q.cnt == 2'h0) begin
                s_d.slot0 = inData;
            end else begin
                s_d.slot1 = inData;
            end
            s_d.cnt = s_q.cnt + 2'h1;
        end else if (pop) begin
            s_d.slot0 = s_q.slot1;
            s_d.cnt = s_q.cnt - 2'h1;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

endmodule // uif_pair_buffer

/* File: uif_line_peer.sv */
// Far-side line peer that offers received characters to the channel.
`timescale 1ns/1ps
module uif_line_peer (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Character offer
    output logic rxInValid,
    output logic [7:0] rxInData,
    input wire logic rxInReady
);
    // ****************
    // Character source
    // ****************
    logic [7:0] nextChar = 8'h5a;
    initial begin
        rxInValid = 1'b0;
        rxInData = 8'ha5;
    end
    // Offers n characters with gap idle cycles after each one.
    // While idle, the data lines toggle so stale values are never taken.
    task automatic send(input int n, input int gap);
        for (int i = 0; i < n; i++) begin
            @(negedge clk);
            rxInValid = 1'b1;
            rxInData = nextChar;
            while (rxInReady !== 1'b1 || reset_n !== 1'b1) @(negedge clk);
            nextChar = nextChar + 8'h01;
            repeat (gap) begin
                @(negedge clk);
                rxInValid = 1'b0;
                rxInData = ~rxInData;
            end
        end
        @(negedge clk);
        rxInValid = 1'b0;
        rxInData = ~rxInData;
    endtask
endmodule // uif_line_peer

/* File: uif_core_tb.sv */
// Self-checking testbench of the interrupt and FIFO control.
`timescale 1ns/1ps
module uif_core_tb
    import uif_pkg::*;
;
    logic clk = 1'b0, reset_n = 1'b0, fcWrite = 1'b0, idRead = 1'b0;
    logic lineStatusRead = 1'b0, rxBufRead = 1'b0, modemStatusRead = 1'b0;
    logic txHoldWrite = 1'b0, charTick = 1'b0, txPop = 1'b0;
    logic rtsPin = 1'b0, ctsPin = 1'b0;
    logic [7:0] fcData = 8'h00, intEnable = 8'h00;
    uif_enh_s enh = '0;
    uif_evt_s evt = '0;
    logic rxInValid, rxInReady, rxMemWe, fifoEnable, dmaMode;
    logic [7:0] rxInData, rxMemAddr, rxMemData, txWrPtr, txRdPtr, rxRdPtr;
    logic [7:0] txLevel, rxLevel, idData;
    int err_count = 0, checks_done = 0, cycles = 0;
    logic [7:0] expChar = 8'h5a;

    always #20 clk = ~clk;

    uif_core uif_core_i (
        .clk(clk), .reset_n(reset_n), .fcWrite(fcWrite), .fcData(fcData),
        .idRead(idRead), .lineStatusRead(lineStatusRead),
        .rxBufRead(rxBufRead), .modemStatusRead(modemStatusRead),
        .txHoldWrite(txHoldWrite), .intEnable(intEnable), .enh(enh),
        .evt(evt), .charTick(charTick), .rtsPin(rtsPin), .ctsPin(ctsPin),
        .txPop(txPop), .rxInValid(rxInValid), .rxInData(rxInData),
        .rxInReady(rxInReady), .rxMemWe(rxMemWe), .rxMemAddr(rxMemAddr),
        .rxMemData(rxMemData), .txWrPtr(txWrPtr), .txRdPtr(txRdPtr),
        .rxRdPtr(rxRdPtr), .txLevel(txLevel), .rxLevel(rxLevel),
        .fifoEnable(fifoEnable), .dmaMode(dmaMode), .idData(idData));

    uif_line_peer peer_i (
        .clk(clk), .reset_n(reset_n), .rxInValid(rxInValid),
        .rxInData(rxInData), .rxInReady(rxInReady));

    // ****************
    // Helpers
    // ****************
    task automatic chk(input string what, input logic [7:0] seen,
                       input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_count++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic pulse(ref logic s);
        @(negedge clk);
        s = 1'b1;
        @(negedge clk);
        s = 1'b0;
    endtask

    task automatic idIs(input string what, input logic [7:0] exp);
        pulse(idRead);
        chk(what, idData, exp);
    endtask

    task automatic fcw(input logic [7:0] d);
        @(negedge clk);
        fcData = d;
        fcWrite = 1'b1;
        @(negedge clk);
        fcWrite = 1'b0;
    endtask

    task automatic ev(input uif_evt_s e);
        @(negedge clk);
        evt = e;
        @(negedge clk);
        evt = '0;
    endtask

    task automatic waitRx(input logic [7:0] exp);
        for (int i = 0; i < 12 && rxLevel !== exp; i++) @(negedge clk);
    endtask

    task automatic txPush(input int n);
        repeat (n) pulse(txHoldWrite);
    endtask

    task automatic finish_test();
        $display("Checks done %0d, errors %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // ****************
    // Scenarios
    // ****************
    task automatic t_reset();
        chk("idData", idData, 8'h00);
        chk("dmaMode", 8'(dmaMode), 8'h00);
        chk("fifoEnable", 8'(fifoEnable), 8'h00);
        chk("rxInReady", 8'(rxInReady), 8'h01);
        idIs("id idle", 8'h01);
        fcw(8'h09);
        chk("fifoEnable", 8'(fifoEnable), 8'h01);
        chk("dmaMode", 8'(dmaMode), 8'h01);
        idIs("id enabled", 8'hc1);
        fcw(8'h01);
        chk("dmaMode", 8'(dmaMode), 8'h00);
        $display("test control done");
    endtask

    task automatic t_priority();
        ev(3'b100);
        idIs("id masked", 8'hc1);
        intEnable = 8'h2c;
        ev(3'b111);
        idIs("id line", 8'hc6);
        pulse(lineStatusRead);
        idIs("id modem", 8'hc0);
        pulse(modemStatusRead);
        idIs("id xoff", 8'hd0);
        idIs("id cleared", 8'hc1);
        intEnable = 8'h00;
        $display("test priority done");
    endtask

    task automatic t_rx();
        intEnable = 8'h01;
        for (int s = 0; s < 4; s++) begin
            fcw({2'(s), 6'h03});
            waitRx(8'h00);
            chk("rxLevel", rxLevel, 8'h00);
            peer_i.send(int'(RX_TRIG[s]) - 1, s);
            waitRx(RX_TRIG[s][7:0] - 8'h01);
            idIs("id below", 8'hc1);
            peer_i.send(1, 0);
            waitRx(RX_TRIG[s][7:0]);
            chk("rxMemAddr", rxMemAddr, RX_TRIG[s][7:0]);
            idIs("id trigger", 8'hc4);
        end
        pulse(rxBufRead);
        idIs("id drop", 8'hc1);
        repeat (4) pulse(charTick);
        idIs("id timeout", 8'hcc);
        pulse(rxBufRead);
        idIs("id read", 8'hc1);
        fcw(8'h00);
        peer_i.send(1, 0);
        repeat (2) @(negedge clk);
        chk("rxLevel", rxLevel, 8'h3a);
        intEnable = 8'h00;
        $display("test receive done");
    endtask

    task automatic t_tx();
        intEnable = 8'h06;
        fcw(8'h35);
        txPush(9);
        chk("txLevel", txLevel, 8'h09);
        pulse(txPop);
        ev(3'b100);
        idIs("id tx line", 8'hc6);
        pulse(lineStatusRead);
        idIs("id tx trig", 8'hc2);
        idIs("id tx read", 8'hc1);
        pulse(txHoldWrite);
        pulse(txPop);
        pulse(txHoldWrite);
        idIs("id tx write", 8'hc1);
        enh.enhEnable = 1'b1;
        fcw(8'h31);
        txPush(48);
        pulse(txPop);
        idIs("id tx 56", 8'hc2);
        intEnable = 8'h00;
        fcw(8'h05);
        txHoldWrite = 1'b1;
        @(negedge clk);
        txHoldWrite = 1'b0;
        chk("txLevel", txLevel, 8'h01);
        chk("txWrPtr", txWrPtr, 8'h01);
        chk("txRdPtr", txRdPtr, 8'h00);
        $display("test transmit done");
    endtask

    task automatic t_big();
        enh.fifo256 = 1'b1;
        fcw(8'h07);
        idIs("id big empty", 8'h81);
        peer_i.send(258, 0);
        chk("rxInReady", 8'(rxInReady), 8'h00);
        chk("rxLevel", rxLevel, 8'h00);
        idIs("id rx full", 8'hc1);
        txPush(256);
        chk("txLevel", txLevel, 8'h00);
        idIs("id tx full", 8'h41);
        repeat (258) pulse(rxBufRead);
        chk("rxRdPtr", rxRdPtr, 8'h02);
        chk("rxInReady", 8'(rxInReady), 8'h01);
        idIs("id rx empty", 8'h01);
        $display("test deep fifo done");
    endtask

    task automatic t_flow();
        enh = 4'b0110;
        fcw(8'h07);
        intEnable = 8'h40;
        rtsPin = 1'b1;
        repeat (6) @(negedge clk);
        idIs("id flow", 8'he0);
        idIs("id flow read", 8'hc1);
        $display("test flow done");
    endtask

    // Every character written to RX storage follows the peer's sequence.
    always @(negedge clk) begin
        if (rxMemWe === 1'b1) begin
            chk("rxMemData", rxMemData, expChar);
            expChar = expChar + 8'h01;
        end
    end

    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            err_count++;
            finish_test();
        end
    end

    initial begin
        repeat (20) @(negedge clk);
        reset_n = 1'b1;
        t_reset();
        t_priority();
        t_rx();
        t_tx();
        t_big();
        t_flow();
        finish_test();
    end
endmodule // uif_core_tb
